// File: src/trr_defines.vh
// Register indices, field positions and reset values of the timer count readback and reload block.
`ifndef TRR_DEFINES_VH
`define TRR_DEFINES_VH

// ==========================================================================
// Register indices (byte address is four times the index)
`define TRR_T0_LO_IDX 8'h63
`define TRR_T0_HI_IDX 8'h64
`define TRR_T1_LO_IDX 8'h68
`define TRR_T1_HI_IDX 8'h69
`define TRR_T2_LO_IDX 8'h72
`define TRR_T2_HI_IDX 8'h73
`define TRR_T3_LO_IDX 8'h77
`define TRR_T3_HI_IDX 8'h78
`define TRR_T0_CTL_IDX 8'h80
`define TRR_T1_CTL_IDX 8'h81
`define TRR_T2_CTL_IDX 8'h82
`define TRR_T3_CTL_IDX 8'h83

// ==========================================================================
// Register kinds returned by the address decoder
`define TRR_K_LO 2'h0
`define TRR_K_HI 2'h1
`define TRR_K_CTL 2'h2

// ==========================================================================
// Control register fields
`define TRR_CTL_EN_BIT 0
`define TRR_CTL_CONT_BIT 1
`define TRR_CTL_FORCE_BIT 2

// ==========================================================================
// Reset values and the end-of-count value
`define TRR_COUNT_RST 16'h0000
`define TRR_RELOAD_RST 16'h0000
`define TRR_HOLD_RST 8'h00
`define TRR_COUNT_EOC 16'h0001

`endif

// File: src/trr_timer.v
// Four 16-bit timers with coherent count readback and write-only reload registers on AHB-Lite.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - A read of the count low byte returns bits 7 to 0 of the live count of that timer at the read.
// - Reading a count byte never disturbs counting or reloading; only the high-byte holding latch changes.
// - Each count low-byte read stores the upper count byte, and a later high-byte read returns that stored byte.
// - The low byte carries count bits 7 to 0 and the high byte carries count bits 15 to 8.
// - Each count byte shares its address with the matching reload byte; reads give count, writes set reload.
// - Each timer holds a 16-bit reload value, low byte bits 7 to 0 and high byte bits 15 to 8.
// - The reload bytes are write-only and cannot be read back at their address.
// - In continuous mode the reload value is loaded into the counter at end-of-count.
// - Writing the force-reload bit as 1 loads the reload value into the counter at the next clock edge.
// - After reset the count, holding latch and reload bytes are all zero.
`include "trr_defines.vh"

module trr_timer (
  // Clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // AHB-Lite slave
  input wire hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire hready_in,
  input wire [31:0] hwdata_in,
  output reg [31:0] hrdata_out,
  output reg hreadyout_out,
  output reg hresp_out,
  // End-of-count pulses, one per timer
  output reg [3:0] eoc_out
);

  // ==========================================================================
  // Address decode

  // Returns {hit, kind, timer} for a register index.
  function [4:0] trr_decode;
    input [7:0] idx;
    begin
      case (idx)
        `TRR_T0_LO_IDX: trr_decode = {1'b1, `TRR_K_LO, 2'h0};
        `TRR_T0_HI_IDX: trr_decode = {1'b1, `TRR_K_HI, 2'h0};
        `TRR_T1_LO_IDX: trr_decode = {1'b1, `TRR_K_LO, 2'h1};
        `TRR_T1_HI_IDX: trr_decode = {1'b1, `TRR_K_HI, 2'h1};
        `TRR_T2_LO_IDX: trr_decode = {1'b1, `TRR_K_LO, 2'h2};
        `TRR_T2_HI_IDX: trr_decode = {1'b1, `TRR_K_HI, 2'h2};
        `TRR_T3_LO_IDX: trr_decode = {1'b1, `TRR_K_LO, 2'h3};
        `TRR_T3_HI_IDX: trr_decode = {1'b1, `TRR_K_HI, 2'h3};
        `TRR_T0_CTL_IDX: trr_decode = {1'b1, `TRR_K_CTL, 2'h0};
        `TRR_T1_CTL_IDX: trr_decode = {1'b1, `TRR_K_CTL, 2'h1};
        `TRR_T2_CTL_IDX: trr_decode = {1'b1, `TRR_K_CTL, 2'h2};
        `TRR_T3_CTL_IDX: trr_decode = {1'b1, `TRR_K_CTL, 2'h3};
        default: trr_decode = 5'h00;
      endcase
    end
  endfunction

  // ==========================================================================
  // State

  reg [15:0] count_r [0:3];
  reg [15:0] reload_r [0:3];
  reg [7:0] hold_r [0:3];
  reg [3:0] en_r;
  reg [3:0] cont_r;
  reg wr_pend_r;
  reg [4:0] wr_dec_r;
  reg [31:0] rd_nxt;
  // Each clocked process has its own loop variable, so no variable is written from two processes.
  integer i;
  integer j;

  wire acc_w;
  wire [4:0] dec_w;
  wire hit_w;
  wire [3:0] rd_tsel_w;
  wire [3:0] wr_tsel_w;
  wire wr_ok_w;

  // Only aligned words inside the low 1 KB window decode; anything else reads zero and ignores writes.
  assign acc_w = hsel_in & htrans_in[1] & hready_in;
  assign dec_w = trr_decode(haddr_in[9:2]);
  assign hit_w = dec_w[4] & (haddr_in[31:10] == 22'h000000) & (haddr_in[1:0] == 2'h0);
  assign rd_tsel_w = 4'h1 << dec_w[1:0];
  assign wr_tsel_w = 4'h1 << wr_dec_r[1:0];
  assign wr_ok_w = wr_pend_r & wr_dec_r[4];

  // ==========================================================================
  // Read data multiplexer

  always @* begin
    rd_nxt = 32'h00000000;
    if (hit_w) begin
      case (dec_w[3:2])
        `TRR_K_LO: rd_nxt = {24'h000000, count_r[dec_w[1:0]][7:0]};
        `TRR_K_HI: rd_nxt = {24'h000000, hold_r[dec_w[1:0]]};
        `TRR_K_CTL: rd_nxt = {29'h0000000, 1'b0, cont_r[dec_w[1:0]], en_r[dec_w[1:0]]};
        default: rd_nxt = 32'h00000000;
      endcase
    end
  end

  // ==========================================================================
  // Bus slave: zero wait states, data captured at the end of the address phase

  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hrdata_out <= 32'h00000000;
      hreadyout_out <= 1'b0;
      hresp_out <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_dec_r <= 5'h00;
      for (i = 0; i < 4; i = i + 1) begin
        hold_r[i] <= `TRR_HOLD_RST;
      end
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
      wr_pend_r <= acc_w & hwrite_in;
      wr_dec_r <= hit_w ? dec_w : 5'h00;
      if (acc_w & ~hwrite_in) begin
        hrdata_out <= rd_nxt;
      end
      // The latch copies the same count sample that the low byte returns, so the pair is coherent.
      for (i = 0; i < 4; i = i + 1) begin
        if (acc_w & ~hwrite_in & hit_w & (dec_w[3:2] == `TRR_K_LO) & rd_tsel_w[i]) begin
          hold_r[i] <= count_r[i][15:8];
        end
      end
    end
  end

  // ==========================================================================
  // Timers: down counters on the system clock

  // A forced reload uses the reload value held before any write landing in the same cycle.
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_r <= 4'h0;
      cont_r <= 4'h0;
      eoc_out <= 4'h0;
      for (j = 0; j < 4; j = j + 1) begin
        count_r[j] <= `TRR_COUNT_RST;
        reload_r[j] <= `TRR_RELOAD_RST;
      end
    end else begin
      for (j = 0; j < 4; j = j + 1) begin
        if (wr_ok_w & wr_tsel_w[j] & (wr_dec_r[3:2] == `TRR_K_LO)) begin
          reload_r[j][7:0] <= hwdata_in[7:0];
        end
        if (wr_ok_w & wr_tsel_w[j] & (wr_dec_r[3:2] == `TRR_K_HI)) begin
          reload_r[j][15:8] <= hwdata_in[7:0];
        end
        eoc_out[j] <= 1'b0;
        if (wr_ok_w & wr_tsel_w[j] & (wr_dec_r[3:2] == `TRR_K_CTL)) begin
          en_r[j] <= hwdata_in[`TRR_CTL_EN_BIT];
          cont_r[j] <= hwdata_in[`TRR_CTL_CONT_BIT];
        end else if (en_r[j] & ~cont_r[j] & (count_r[j] == `TRR_COUNT_EOC)) begin
          en_r[j] <= 1'b0;
        end
        if (wr_ok_w & wr_tsel_w[j] & (wr_dec_r[3:2] == `TRR_K_CTL) & hwdata_in[`TRR_CTL_FORCE_BIT]) begin
          count_r[j] <= reload_r[j];
        end else if (en_r[j] & (count_r[j] == `TRR_COUNT_EOC)) begin
          eoc_out[j] <= 1'b1;
          count_r[j] <= cont_r[j] ? reload_r[j] : 16'h0000;
        end else if (en_r[j]) begin
          count_r[j] <= count_r[j] - 16'h0001;
        end
      end
    end
  end

endmodule // trr_timer

// File: bench/trr_timer_asserts.sv
// Concurrent checks on the ports of the timer block.
`timescale 1ns/1ps
// ========================================
// Checker
module trr_chk (
  input wire clk_in, input wire rst_n_in, input wire hsel_in, input wire [31:0] haddr_in,
  input wire [1:0] htrans_in, input wire hwrite_in, input wire [2:0] hsize_in, input wire hready_in,
  input wire [31:0] hwdata_in, input wire [31:0] hrdata_out, input wire hreadyout_out,
  input wire hresp_out, input wire [3:0] eoc_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  wire rd = hsel_in && htrans_in[1] && hready_in && !hwrite_in;
  wire wr = hsel_in && htrans_in[1] && hready_in && hwrite_in;
  chk_resp_okay: assert property (hresp_out == 1'b0) else $error("bad response");
  chk_ready_holds: assert property (hreadyout_out |=> hreadyout_out) else $error("ready dropped");
  chk_byte_only: assert property (hrdata_out[31:8] == 24'h0) else $error("upper data set");
  chk_idle_keeps: assert property (!rd |=> $stable(hrdata_out)) else $error("data moved");
  chk_write_keeps: assert property (wr |=> hrdata_out == $past(hrdata_out)) else $error("write shown");
  chk_unmapped_zero: assert property (rd && haddr_in == 32'h3fc |=> hrdata_out == 32'h0) else $error("unmapped");
  chk_high_latched: assert property (rd && haddr_in == 32'h190 ##1 !rd ##1 rd && haddr_in == 32'h190
    |=> $stable(hrdata_out)) else $error("high byte moved");
  chk_reset_zero: assert property ($rose(hreadyout_out) |-> hrdata_out == 32'h0 && eoc_out == 4'h0)
    else $error("reset value");
  cover property (eoc_out[1]);
  cover property (rd && haddr_in == 32'h18c);
  cover property (wr && haddr_in == 32'h200);
endmodule // trr_chk

bind trr_timer trr_chk trr_chk_i (.*);

// File: bench/tb_top.sv
// Self-checking bench of the timer block.
`timescale 1ns/1ps
// ========================================
// Bench
module tb_top;
  reg clk_in = 1'b0, rst_n_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0;
  reg [1:0] htrans_in = 2'h0;
  reg [2:0] hsize_in = 3'h2;
  reg [31:0] haddr_in = 32'h0, hwdata_in = 32'h0, rd_v;
  wire [31:0] hrdata_out;
  wire hreadyout_out, hresp_out;
  wire [3:0] eoc_out;
  integer num_errors = 0, num_checks = 0, i;
  reg [31:0] lo_a [0:3] = '{32'h18c, 32'h1a0, 32'h1c8, 32'h1dc};
  always #2 clk_in = ~clk_in;
  trr_timer trr_timer_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hready_in(hreadyout_out),
    .hwdata_in(hwdata_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .eoc_out(eoc_out));
  task bus(input [31:0] a, input w, input [31:0] d);
    begin
      hsel_in <= 1'b1;
      haddr_in <= a;
      hwrite_in <= w;
      htrans_in <= 2'h2;
      @(posedge clk_in);
      while (hreadyout_out !== 1'b1) @(posedge clk_in);
      hsel_in <= 1'b0;
      htrans_in <= 2'h0;
      hwdata_in <= d;
      @(posedge clk_in);
      while (hreadyout_out !== 1'b1) @(posedge clk_in);
      rd_v = hrdata_out;
    end
  endtask
  // A range is accepted because a running timer is read at a moment the bench cannot pin down.
  task chk(input [31:0] a, input [7:0] lo, input [7:0] hi);
    begin
      bus(a, 1'b0, 32'h0);
      num_checks = num_checks + 1;
      if ((rd_v >= {24'h0, lo} && rd_v <= {24'h0, hi}) !== 1'b1) begin
        num_errors = num_errors + 1;
        $display("BAD %0t read %h gave %h", $time, a, rd_v);
      end
    end
  endtask
  task report_and_stop;
    begin
      if (num_errors == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    #20000;
    num_errors = num_errors + 1;
    report_and_stop;
  end
  initial begin
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    for (i = 0; i < 4; i = i + 1) begin
      chk(lo_a[i], 8'h00, 8'h00);
      chk(lo_a[i] + 32'h4, 8'h00, 8'h00);
      bus(lo_a[i], 1'b1, 32'h34 + i);
      bus(lo_a[i] + 32'h4, 1'b1, 32'h12 + i);
      chk(lo_a[i], 8'h00, 8'h00);
      bus(32'h200 + 4 * i, 1'b1, 32'h4);
      chk(lo_a[i], 8'h34 + i[7:0], 8'h34 + i[7:0]);
      chk(lo_a[i] + 32'h4, 8'h12 + i[7:0], 8'h12 + i[7:0]);
    end
    chk(32'h18c, 8'h34, 8'h34);
    bus(32'h190, 1'b1, 32'h56);
    bus(32'h200, 1'b1, 32'h4);
    chk(32'h190, 8'h12, 8'h12);
    chk(32'h190, 8'h12, 8'h12);
    chk(32'h18c, 8'h34, 8'h34);
    chk(32'h190, 8'h56, 8'h56);
    chk(32'h3fc, 8'h00, 8'h00);
    bus(32'h1a4, 1'b1, 32'h0);
    bus(32'h1a0, 1'b1, 32'h5);
    bus(32'h204, 1'b1, 32'h7);
    while (eoc_out[1] !== 1'b1) @(posedge clk_in);
    repeat (20) @(posedge clk_in);
    chk(32'h1a0, 8'h01, 8'h05);
    chk(32'h1a4, 8'h00, 8'h00);
    rst_n_in <= 1'b0;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    chk(32'h1a0, 8'h00, 8'h00);
    bus(32'h204, 1'b1, 32'h4);
    chk(32'h1a0, 8'h00, 8'h00);
    report_and_stop;
  end
endmodule // tb_top
